/* File: tb/test_measurement_trigger_control.sv */
`timescale 1ns/1ps
module test_measurement_trigger_control;
  reg         clk = 1'b0;
  reg         reset_n = 1'b0;
  reg  [1:0]  cmd_mode = 2'h0;
  reg         cmd_mode_valid = 1'b0;
  reg  [15:0] storage_interval_command = 16'h0004;
  reg         cmd_interval_valid = 1'b0;
  reg  [15:0] cmd_buf_size = 16'h0003;
  reg         cmd_size_valid = 1'b0;
  reg         cmd_execute = 1'b0;
  reg         remote_state = 1'b0;
  reg         local_key = 1'b0;
  reg         enter_key = 1'b0;
  reg         store_enable = 1'b0;
  reg         tb_trig_n = 1'b1;
  reg         conv_done = 1'b0;
  reg         go = 1'b0;
  reg         rd_q = 1'b1;
  reg  [1:0]  cur = 2'h0;
  reg  [15:0] lfsr = 16'h0247;
  wire        scan_trig_n, ext_trig_n, conv_start, store_write, storing, reading_done_n;
  wire [15:0] store_index;
  wire [1:0]  mode_out;
  wire [7:0]  advanced;
  integer     fail_count = 0, checks_done = 0, dones = 0, base = 0, k;
  assign ext_trig_n = scan_trig_n & tb_trig_n;
  always #5 clk = ~clk;
  measurement_trigger_control dut_u (
    .clk                      (clk),
    .reset_n                  (reset_n),
    .cmd_mode                 (cmd_mode),
    .cmd_mode_valid           (cmd_mode_valid),
    .storage_interval_command (storage_interval_command),
    .cmd_interval_valid       (cmd_interval_valid),
    .cmd_buf_size             (cmd_buf_size),
    .cmd_size_valid           (cmd_size_valid),
    .cmd_execute              (cmd_execute),
    .remote_state             (remote_state),
    .local_key                (local_key),
    .enter_key                (enter_key),
    .store_enable             (store_enable),
    .ext_trig_n               (ext_trig_n),
    .conv_done                (conv_done),
    .conv_start               (conv_start),
    .store_write              (store_write),
    .store_index              (store_index),
    .storing                  (storing),
    .mode_out                 (mode_out),
    .reading_done_n           (reading_done_n)
  );
  trig_scanner scan_u (.clk(clk), .go(go), .settle(lfsr[7:4]),
    .reading_done_n(reading_done_n), .ext_trig_n(scan_trig_n), .advanced(advanced));
  function [15:0] next_rand(input [15:0] s);
    next_rand = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // conversion with random latency
  always @(negedge clk) if (conv_start) begin
    lfsr = next_rand(lfsr);
    repeat (3 + lfsr[3:0]) @(negedge clk);
    conv_done = 1'b1;
    repeat (2) @(negedge clk);
    conv_done = 1'b0;
  end
  always @(posedge clk) begin
    rd_q <= reading_done_n;
    if (rd_q && !reading_done_n) dones <= dones + 1;
  end
  task chk(input [127:0] what, input [15:0] exp, input [15:0] got);
    begin
      checks_done = checks_done + 1;
      if (exp !== got) begin
        fail_count = fail_count + 1;
        $display("unexpected %0s: expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task wait_dones(input integer n);
    begin
      k = 0;
      while (dones < n && k < 5000) begin
        @(negedge clk);
        k = k + 1;
      end
      chk("reading count", n[15:0], dones[15:0]);
      if (dones < n) tally_and_finish;
    end
  endtask
  task apply(input [1:0] m);
    begin
      cmd_mode = m;
      cmd_mode_valid = 1'b1;
      cmd_interval_valid = 1'b1;
      cmd_size_valid = 1'b1;
      @(negedge clk);
      cmd_mode_valid = 1'b0;
      cmd_interval_valid = 1'b0;
      cmd_size_valid = 1'b0;
      repeat (3) @(negedge clk);
      chk("staged mode", {14'h0000, cur}, {14'h0000, mode_out});
      cmd_execute = 1'b1;
      @(negedge clk);
      cmd_execute = 1'b0;
      repeat (300) @(negedge clk);
      chk("applied mode", {14'h0000, m}, {14'h0000, mode_out});
      cur = m;
      base = dones;
    end
  endtask
  task press;
    begin
      enter_key = 1'b1;
      repeat (4) @(negedge clk);
      enter_key = 1'b0;
    end
  endtask
  initial begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    chk("reset mode", 16'h0000, {14'h0000, mode_out});
    wait_dones(2);
    $display("test internal done");
    apply(2'h1);
    store_enable = 1'b1;
    go = 1'b1;
    wait_dones(base + 3);
    repeat (900) @(negedge clk);
    chk("scanner channels", 16'h0003, {8'h00, advanced});
    chk("stored readings", 16'h0003, store_index);
    chk("pulses when full", base[15:0] + 16'h0003, dones[15:0]);
    chk("storing when full", 16'h0000, {15'h0000, storing});
    $display("test scanner done");
    store_enable = 1'b0;
    apply(2'h0);
    apply(2'h1);
    store_enable = 1'b1;
    remote_state = 1'b1;
    press;
    remote_state = 1'b0;
    repeat (300) @(negedge clk);
    chk("enter under remote", 16'h0000, store_index);
    local_key = 1'b1;
    repeat (4) @(negedge clk);
    local_key = 1'b0;
    press;
    wait_dones(base + 1);
    repeat (3) @(negedge clk);
    chk("enter one shot", 16'h0001, store_index);
    $display("test enter done");
    store_enable = 1'b0;
    tb_trig_n = 1'b0;
    apply(2'h2);
    tb_trig_n = 1'b1;
    repeat (300) @(negedge clk);
    chk("rising edge", base[15:0], dones[15:0]);
    tb_trig_n = 1'b0;
    wait_dones(base + 3);
    tb_trig_n = 1'b1;
    apply(2'h2);
    store_enable = 1'b1;
    press;
    wait_dones(base + 2);
    repeat (3) @(negedge clk);
    chk("continuous store", 16'h0001, {15'h0000, store_index >= 16'h0002});
    $display("test continuous done");
    tally_and_finish;
  end
endmodule // test_measurement_trigger_control
bind measurement_trigger_control trig_ctrl_checker chk_u (
  .clk            (clk),
  .reset_n        (reset_n),
  .ext_trig_n     (ext_trig_n),
  .conv_done      (conv_done),
  .store_enable   (store_enable),
  .conv_start     (conv_start),
  .store_write    (store_write),
  .store_index    (store_index),
  .storing        (storing),
  .mode_out       (mode_out),
  .reading_done_n (reading_done_n)
);

/* File: tb/trig_ctrl_assertions.sv */
`timescale 1ns/1ps
module trig_ctrl_checker (
  input wire        clk,
  input wire        reset_n,
  input wire        ext_trig_n,
  input wire        conv_done,
  input wire        store_enable,
  input wire        conv_start,
  input wire        store_write,
  input wire [15:0] store_index,
  input wire        storing,
  input wire [1:0]  mode_out,
  input wire        reading_done_n
);
  reg busy_q;
  reg done_q;
  // conversion in flight, from start until the complete pulse falls
  always @(posedge clk) begin
    done_q <= reading_done_n;
    if (!reset_n) busy_q <= 1'b0;
    else if (conv_start) busy_q <= 1'b1;
    else if (done_q && !reading_done_n) busy_q <= 1'b0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_reset_mode: assert property ($rose(reset_n) |-> mode_out == 2'h0)
    else $error("mode not continuous internal after reset");
  chk_done_follows: assert property ($rose(conv_done) && reading_done_n |-> ##[1:5] $fell(reading_done_n))
    else $error("no complete pulse after conversion");
  chk_done_width: assert property ($fell(reading_done_n) |-> ##99 !reading_done_n ##1 reading_done_n)
    else $error("complete pulse width wrong");
  chk_trig_starts: assert property (mode_out == 2'h1 && $fell(ext_trig_n) && !busy_q
    && !conv_start && !conv_done && reading_done_n && !(store_enable && !storing)
    |-> ##[2:6] conv_start)
    else $error("falling trigger did not start a reading");
  chk_busy_refuse: assert property (busy_q |-> !conv_start)
    else $error("second start during a conversion");
  chk_store_on_done: assert property ($fell(reading_done_n) && $past(storing) |-> store_write)
    else $error("finished reading not stored");
  chk_write_on_done: assert property (store_write |-> $fell(reading_done_n))
    else $error("store write without a finished reading");
  chk_index_step: assert property (store_write |-> store_index == $past(store_index) + 16'h0001)
    else $error("store index did not step by one");
  chk_internal_pace: assert property ($fell(reading_done_n) && mode_out == 2'h0
    |-> ##[1:1000] (conv_start || mode_out != 2'h0))
    else $error("internal time base stalled");
  cover property (mode_out == 2'h1 && conv_start);
  cover property (mode_out == 2'h2 && conv_start);
  cover property (store_enable && !storing);
endmodule // trig_ctrl_checker

/* File: tb/trig_scanner.sv */
`timescale 1ns/1ps
module trig_scanner (
  input wire       clk,
  input wire       go,
  input wire [3:0] settle,
  input wire       reading_done_n,
  output reg       ext_trig_n,
  output reg [7:0] advanced
);
  integer ch;
  integer n;
  initial begin
    ext_trig_n = 1'b1;
    advanced = 8'h00;
    wait (go);
    for (ch = 0; ch < 4; ch = ch + 1) begin
      repeat (settle + 1) @(negedge clk);
      ext_trig_n = 1'b0;
      repeat (3) @(negedge clk);
      ext_trig_n = 1'b1;
      n = 0;
      while (reading_done_n && n < 400) begin
        @(negedge clk);
        n = n + 1;
      end
      if (!reading_done_n) advanced = advanced + 8'h01;
      while (!reading_done_n && n < 800) begin
        @(negedge clk);
        n = n + 1;
      end
    end
  end
endmodule // trig_scanner

/* File: verilog/edge_sync.v */
`timescale 1ns/1ps
// two-stage synchroniser with falling-edge detect
module edge_sync (
  clk,
  reset_n,
  async_in,
  fall_pulse
);
  input  wire clk;
  input  wire reset_n;
  input  wire async_in;
  output reg  fall_pulse;

  reg meta_q;
  reg sync_q;
  reg prev_q;

  always @(posedge clk) begin
    if (!reset_n) begin
      meta_q     <= 1'b1;
      sync_q     <= 1'b1;
      prev_q     <= 1'b1;
      fall_pulse <= 1'b0;
    end else begin
      meta_q     <= async_in;
      sync_q     <= meta_q;
      prev_q     <= sync_q;
      fall_pulse <= prev_q & ~sync_q;
    end
  end
endmodule // edge_sync

/* File: verilog/measurement_trigger_control.v */
// Operation
// - one-shot with storage: each enter press stores exactly one reading; code stores none with the buffer full.
// - continuous mode: enter press starts storage at programmed interval.
// - one_shot_ext_trigger_mode gives one reading per external trigger; code ignores triggers with store_enable on and the buffer full.
// - continuous_ext_trigger_mode: trigger starts an ongoing reading series.
// - separate commands set storage interval and buffer size.
// - one-shot: one reading per trigger, then wait.
// - continuous: once triggered, readings run back to back.
// - external trigger recognised only on falling edge, both modes.
// - storage with one-shot: every external trigger stores one reading; code stores none with store_enable on and the buffer full.
// - one active-low reading-complete pulse per finished reading.
// - continuous: complete pulses follow each finished conversion.
// - one-shot: exactly one complete pulse per trigger; code gives no pulse with store_enable on and the buffer full.
// - enter key triggers only after local key returns control.
// - after reset, continuous mode paced by internal time base.
// - mode and storage commands apply only on execute character.
`timescale 1ns/1ps
`include "trig_ctrl_regs.vh"
module measurement_trigger_control #(
  parameter IW = 16,
  parameter SW = 16,
  parameter PW = 8
) (
  clk,
  reset_n,
  cmd_mode,
  cmd_mode_valid,
  storage_interval_command,
  cmd_interval_valid,
  cmd_buf_size,
  cmd_size_valid,
  cmd_execute,
  remote_state,
  local_key,
  enter_key,
  store_enable,
  ext_trig_n,
  conv_done,
  conv_start,
  store_write,
  store_index,
  storing,
  mode_out,
  reading_done_n
);
  input  wire          clk;
  input  wire          reset_n;
  input  wire [1:0]    cmd_mode;
  input  wire          cmd_mode_valid;
  input  wire [IW-1:0] storage_interval_command;
  input  wire          cmd_interval_valid;
  input  wire [SW-1:0] cmd_buf_size;
  input  wire          cmd_size_valid;
  input  wire          cmd_execute;
  input  wire          remote_state;
  input  wire          local_key;
  input  wire          enter_key;
  input  wire          store_enable;
  input  wire          ext_trig_n;
  input  wire          conv_done;
  output reg           conv_start;
  output reg           store_write;
  output reg  [SW-1:0] store_index;
  output reg           storing;
  output reg  [1:0]    mode_out;
  output reg           reading_done_n;

  localparam ST_IDLE = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_WAIT = 2'h2;
  localparam [PW-1:0] PULSE_CYC = `DONE_PULSE_CYC;

  // pending commands, applied on execute
  reg [1:0]    pend_mode_q;
  reg          pend_mode_v_q;
  reg [IW-1:0] pend_int_q;
  reg          pend_int_v_q;
  reg [SW-1:0] pend_size_q;
  reg          pend_size_v_q;
  reg [IW-1:0] interval_q;
  reg [SW-1:0] buf_size_q;
  reg          local_ctl_q;
  reg          run_q;
  reg [1:0]    state_q;
  reg [IW-1:0] wait_cnt_q;
  reg [PW-1:0] pulse_cnt_q;
  reg          ent_m_q;
  reg          ent_s_q;
  reg          ent_p_q;
  reg          loc_m_q;
  reg          loc_s_q;
  reg          done_m_q;
  reg          done_s_q;
  reg          done_p_q;
  wire         ext_fall;
  reg          enter_press;
  reg          done_rise;
  reg          ext_mode;
  reg          trig;
  reg          buf_full;

  edge_sync u_ext (
    .clk        (clk),
    .reset_n    (reset_n),
    .async_in   (ext_trig_n),
    .fall_pulse (ext_fall)
  );

  // front-panel and converter inputs synchronised
  always @(posedge clk) begin
    if (!reset_n) begin
      ent_m_q  <= 1'b0;
      ent_s_q  <= 1'b0;
      ent_p_q  <= 1'b0;
      loc_m_q  <= 1'b0;
      loc_s_q  <= 1'b0;
      done_m_q <= 1'b0;
      done_s_q <= 1'b0;
      done_p_q <= 1'b0;
    end else begin
      ent_m_q  <= enter_key;
      ent_s_q  <= ent_m_q;
      ent_p_q  <= ent_s_q;
      loc_m_q  <= local_key;
      loc_s_q  <= loc_m_q;
      done_m_q <= conv_done;
      done_s_q <= done_m_q;
      done_p_q <= done_s_q;
    end
  end

  // trigger qualification
  always @* begin
    ext_mode    = 1'b0;
    enter_press = 1'b0;
    done_rise   = 1'b0;
    trig        = 1'b0;
    buf_full    = 1'b0;
    if ((mode_out == `MODE_ONE_SHOT_EXT) || (mode_out == `MODE_CONT_EXT)) begin
      ext_mode = 1'b1;
    end
    if (ent_s_q && !ent_p_q && local_ctl_q) begin
      enter_press = 1'b1;
    end
    if (done_s_q && !done_p_q) begin
      done_rise = 1'b1;
    end
    if (ext_mode && (ext_fall || enter_press)) begin
      trig = 1'b1;
    end
    if (store_enable && (store_index >= buf_size_q)) begin
      buf_full = 1'b1;
    end
  end

  // bus command staging and execute
  always @(posedge clk) begin
    if (!reset_n) begin
      pend_mode_q   <= `MODE_CONT_INTERNAL;
      pend_mode_v_q <= 1'b0;
      pend_int_q    <= `RST_INTERVAL;
      pend_int_v_q  <= 1'b0;
      pend_size_q   <= `RST_BUF_SIZE;
      pend_size_v_q <= 1'b0;
      mode_out      <= `MODE_CONT_INTERNAL;
      interval_q    <= `RST_INTERVAL;
      buf_size_q    <= `RST_BUF_SIZE;
    end else if (cmd_execute) begin
      if (pend_mode_v_q) begin
        mode_out <= pend_mode_q;
      end
      if (pend_int_v_q) begin
        interval_q <= pend_int_q;
      end
      if (pend_size_v_q) begin
        buf_size_q <= pend_size_q;
      end
      pend_mode_v_q <= 1'b0;
      pend_int_v_q  <= 1'b0;
      pend_size_v_q <= 1'b0;
    end else begin
      if (cmd_mode_valid) begin
        pend_mode_q   <= cmd_mode;
        pend_mode_v_q <= 1'b1;
      end
      if (cmd_interval_valid) begin
        pend_int_q   <= storage_interval_command;
        pend_int_v_q <= 1'b1;
      end
      if (cmd_size_valid) begin
        pend_size_q   <= cmd_buf_size;
        pend_size_v_q <= 1'b1;
      end
    end
  end

  // local/remote control hand-back
  always @(posedge clk) begin
    if (!reset_n) begin
      local_ctl_q <= 1'b1;
    end else if (loc_s_q) begin
      local_ctl_q <= 1'b1;
    end else if (remote_state) begin
      local_ctl_q <= 1'b0;
    end
  end

  // continuous run flag
  always @(posedge clk) begin
    if (!reset_n) begin
      run_q <= 1'b1;
    end else if (cmd_execute && pend_mode_v_q) begin
      run_q <= (pend_mode_q == `MODE_CONT_INTERNAL);
    end else if (mode_out == `MODE_CONT_EXT && trig) begin
      run_q <= 1'b1;
    end
  end

  // store status flag
  always @(posedge clk) begin
    if (!reset_n) begin
      storing <= 1'b0;
    end else begin
      storing <= store_enable & ~buf_full;
    end
  end

  // stored reading counter, cleared whenever a mode command executes
  always @(posedge clk) begin
    if (!reset_n) begin
      store_index <= {SW{1'b0}};
    end else if (cmd_execute && pend_mode_v_q) begin
      store_index <= {SW{1'b0}};
    end else if (state_q == ST_CONV && done_rise && store_enable && !buf_full) begin
      store_index <= store_index + 1'b1;
    end
  end

  // reading sequencer
  always @(posedge clk) begin
    if (!reset_n) begin
      state_q     <= ST_IDLE;
      conv_start  <= 1'b0;
      store_write <= 1'b0;
      wait_cnt_q  <= {IW{1'b0}};
    end else begin
      conv_start  <= 1'b0;
      store_write <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          // no new reading while the complete pulse is low, so pulses never merge
          if (!reading_done_n || (buf_full && mode_out != `MODE_CONT_INTERNAL)) begin
            state_q <= ST_IDLE;
          end else if ((mode_out == `MODE_ONE_SHOT_EXT && trig) ||
                       (mode_out != `MODE_ONE_SHOT_EXT && run_q)) begin
            conv_start <= 1'b1;
            state_q    <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (done_rise) begin
            if (store_enable && !buf_full) begin
              store_write <= 1'b1;
            end
            wait_cnt_q <= interval_q;
            state_q    <= (mode_out == `MODE_ONE_SHOT_EXT) ? ST_IDLE : ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (wait_cnt_q == {IW{1'b0}}) begin
            state_q <= ST_IDLE;
          end else begin
            wait_cnt_q <= wait_cnt_q - 1'b1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // reading-complete pulse, one per finished reading
  always @(posedge clk) begin
    if (!reset_n) begin
      reading_done_n <= 1'b1;
      pulse_cnt_q    <= {PW{1'b0}};
    end else if (state_q == ST_CONV && done_rise) begin
      reading_done_n <= 1'b0;
      pulse_cnt_q    <= PULSE_CYC;
    end else if (pulse_cnt_q > 1) begin
      pulse_cnt_q <= pulse_cnt_q - 1'b1;
    end else begin
      pulse_cnt_q    <= {PW{1'b0}};
      reading_done_n <= 1'b1;
    end
  end
endmodule // measurement_trigger_control

/* File: verilog/trig_ctrl_regs.vh */
`ifndef TRIG_CTRL_REGS_VH
`define TRIG_CTRL_REGS_VH
// trigger mode codes
`define MODE_CONT_INTERNAL   2'h0
`define MODE_ONE_SHOT_EXT    2'h1
`define MODE_CONT_EXT        2'h2
`define MODE_W               2
// reset values
`define RST_INTERVAL         16'h0000
`define RST_BUF_SIZE         16'h0064
// reading-complete pulse low time in ns
`define DONE_PULSE_NS        1000
`define CLK_NS               10
// pulse low time in clock cycles, 1000 ns at 10 ns
`define DONE_PULSE_CYC       8'h64
`endif
